/* rtl/alu_core.sv */
`timescale 1ns/1ps
module alu_core (
	alu_if.alu bus
);
	localparam int DW = exec_pkg::DW;
	localparam int NW = exec_pkg::NIB_W;
	logic [DW:0] sum;
	logic [NW:0] nib;

	// full sum and low nibble carry
	assign sum = {1'b0, bus.a} + {1'b0, bus.b} + {{DW{1'b0}}, bus.cin};
	assign nib = {1'b0, bus.a[NW-1:0]} + {1'b0, bus.b[NW-1:0]}
		+ {{NW{1'b0}}, bus.cin};

	// result and carry-type flags per operation
	always_comb begin
		bus.res = sum[DW-1:0];
		bus.c   = sum[DW];
		bus.dc  = nib[NW];
		bus.ov  = (bus.a[DW-1] == bus.b[DW-1]) &&
			(sum[DW-1] != bus.a[DW-1]);
		case (bus.op)
			exec_pkg::ALU_AND: begin
				bus.res = bus.a & bus.b;
				bus.c   = 1'b0;
				bus.dc  = 1'b0;
				bus.ov  = 1'b0;
			end
			exec_pkg::ALU_ASR1: begin
				bus.res = {bus.a[DW-1], bus.a[DW-1:1]};
				bus.c   = bus.a[0];
				bus.dc  = 1'b0;
				bus.ov  = 1'b0;
			end
			exec_pkg::ALU_ASRN: begin
				bus.res = $signed(bus.a) >>> bus.b[exec_pkg::SHC_W-1:0];
				bus.c   = 1'b0;
				bus.dc  = 1'b0;
				bus.ov  = 1'b0;
			end
			default: begin
			end
		endcase
	end
endmodule : alu_core

/* rtl/alu_if.sv */
`timescale 1ns/1ps
interface alu_if;
	logic [exec_pkg::DW-1:0] a;
	logic [exec_pkg::DW-1:0] b;
	logic                    cin;
	exec_pkg::alu_op_e       op;
	logic [exec_pkg::DW-1:0] res;
	logic                    c;
	logic                    dc;
	logic                    ov;
	modport drv (output a, b, cin, op, input res, c, dc, ov);
	modport alu (input a, b, cin, op, output res, c, dc, ov);
endinterface : alu_if

/* rtl/ea_calc.sv */
`timescale 1ns/1ps
module ea_calc (
	input  wire logic [15:0] ptr,
	input  wire logic [15:0] pre,
	input  wire logic [15:0] post,
	input  wire logic [15:0] idx,
	output logic      [15:0] ea,
	output logic      [15:0] upd
);
	// effective address and written-back pointer
	assign ea  = ptr + pre + idx;
	assign upd = ptr + pre + post;
endmodule : ea_calc

/* rtl/exec_pkg.sv */
package exec_pkg;
	localparam int DW      = 16;
	localparam int ACC_W   = 40;
	localparam int INSTR_W = 24;
	localparam int OPC_W   = 8;
	localparam int RIX_W   = 4;
	localparam int SHC_W   = 4;
	localparam int NIB_W   = 4;
	// ************************************************
	// instruction fields (lsb positions)
	// ************************************************
	localparam int OPC_LSB   = 16;
	localparam int BASE_LSB  = 12;
	localparam int SRC_LSB   = 8;
	localparam int SMODE_LSB = 5;
	localparam int DST_LSB   = 0;
	localparam int L10_LSB   = 4;
	localparam int L10_W     = 10;
	localparam int L5_LSB    = 4;
	localparam int L5_W      = 5;
	localparam int SLIT_LSB  = 0;
	localparam int FILE_LSB  = 0;
	localparam int FILE_DEFAULT_FILE_OPERAND_REG = 14;
	localparam int PAIR_LSB  = 13;
	localparam int XPF_LSB   = 9;
	localparam int YPF_LSB   = 5;
	localparam int XD_LSB    = 3;
	localparam int YD_LSB    = 1;
	localparam int DIVM_LSB  = 4;
	localparam int DIVN_LSB  = 0;
	localparam int CARRY_BIT = 3;
	// ************************************************
	// opcodes, groups and forms
	// ************************************************
	localparam logic [3:0] GRP_ADD = 4'h1;
	localparam logic [3:0] GRP_AND = 4'h2;
	localparam logic [3:0] GRP_ASR = 4'h3;
	localparam logic [7:0] OP_ACC  = 8'h40;
	localparam logic [7:0] OP_MAC  = 8'h50;
	localparam logic [7:0] OP_DIV  = 8'h58;
	localparam logic [1:0] FORM_FILE = 2'h0;
	localparam logic [1:0] FORM_L10  = 2'h1;
	localparam logic [1:0] FORM_RRR  = 2'h2;
	localparam logic [1:0] FORM_L5   = 2'h3;
	localparam logic [2:0] PAIR_LAST = 3'h5;
	// ************************************************
	// addressing modes and prefetch codes
	// ************************************************
	localparam logic [2:0] AM_DIRECT  = 3'h0;
	localparam logic [2:0] AM_POSTINC = 3'h2;
	localparam logic [2:0] AM_POSTDEC = 3'h3;
	localparam logic [2:0] AM_PREINC  = 3'h4;
	localparam logic [2:0] AM_PREDEC  = 3'h5;
	localparam logic [2:0] AM_INDEX   = 3'h6;
	localparam logic [15:0] STEP_P  = 16'h0002;
	localparam logic [15:0] STEP_N  = 16'hFFFE;
	localparam logic [15:0] PF_MAX  = 16'h0006;
	localparam logic [2:0]  PF_PLAIN = 3'h3;
	localparam logic [3:0]  PF_INDEX = 4'h7;
	localparam logic [3:0]  PF_NONE  = 4'hF;
	// ************************************************
	// working register numbers
	// ************************************************
	localparam logic [3:0] W0 = 4'h0;
	localparam logic [3:0] W1 = 4'h1;
	localparam logic [3:0] W4 = 4'h4;
	localparam logic [3:0] W5 = 4'h5;
	localparam logic [3:0] W6 = 4'h6;
	localparam logic [3:0] W7 = 4'h7;
	localparam logic [3:0] W8 = 4'h8;
	localparam logic [3:0] W9 = 4'h9;
	localparam logic [3:0] W10 = 4'hA;
	localparam logic [3:0] W11 = 4'hB;
	localparam logic [3:0] W12 = 4'hC;
	// ************************************************
	// register map and status layout
	// ************************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] A_INSTR  = 12'h040;
	localparam logic [11:0] A_STATUS = 12'h044;
	localparam logic [11:0] A_ACCA_L = 12'h048;
	localparam logic [11:0] A_ACCA_H = 12'h04C;
	localparam logic [11:0] A_ACCB_L = 12'h050;
	localparam logic [11:0] A_ACCB_H = 12'h054;
	localparam logic [1:0]  MEM_WIN  = 2'h1;
	localparam int STATUS_W = 10;
	localparam int ST_C = 0;
	localparam int ST_Z = 1;
	localparam int ST_OV = 2;
	localparam int ST_N = 3;
	localparam int ST_DC = 4;
	localparam int ST_OA = 5;
	localparam int ST_OB = 6;
	localparam int ST_SA = 7;
	localparam int ST_SB = 8;
	localparam int ST_BAD = 9;
	localparam logic [9:0] STATUS_RST = 10'h000;
	localparam logic [39:0] ACC_MAX = 40'h7FFFFFFFFF;
	localparam logic [39:0] ACC_MIN = 40'h8000000000;

	typedef enum logic [1:0] {
		ALU_ADD, ALU_AND, ALU_ASR1, ALU_ASRN
	} alu_op_e;

	// signed post-modify step for prefetch code k
	function automatic logic [15:0] pf_delta(input logic [2:0] k);
		logic [15:0] mag;
		mag = (k < PF_PLAIN) ? PF_MAX - {12'h0, k, 1'b0} :
			(k > PF_PLAIN) ? PF_MAX - {12'h0, k - 3'h4, 1'b0} : 16'h0;
		return (k > PF_PLAIN) ? 16'h0 - mag : mag;
	endfunction : pf_delta
endpackage : exec_pkg

/* rtl/operand_select_add_logic_shift.sv */
`timescale 1ns/1ps
// How it works
// - register fields pick one of sixteen registers
// - file forms use W0 as default operand
// - divide pair uses direct registers only
// - square pairs only W4..W7 with itself
// - multiply takes six fixed W4..W7 pairs
// - X prefetch via W8/W9, steps, W12 index
// - Y prefetch via W10/W11, steps, W12 index
// - prefetched data lands in W4..W7
// - accumulator source supports all addressing modes
// - add-with-carry file form updates five flags
// - ten-bit and five-bit literal add forms
// - signed accumulator add touches overflow, saturation
// - single shift keeps sign, updates C,N,OV,Z
// - shift by register count updates N,Z
// - every form completes in one cycle
// - 24-bit word, 8-bit opcode field
// - core and accumulator status flag sets
module operand_select_add_logic_shift #(
	parameter int DEPTH = 256
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	localparam int DW = exec_pkg::DW;
	localparam int AW = exec_pkg::ACC_W;
	localparam int MA = $clog2(DEPTH);

	logic [DW-1:0] w_reg [16];
	logic [DW-1:0] w_next [16];
	logic [DW-1:0] mem [DEPTH];
	logic [exec_pkg::INSTR_W-1:0] instr_reg;
	logic [exec_pkg::STATUS_W-1:0] st_reg, st_next;
	logic [AW-1:0] acca_reg, acca_next, accb_reg, accb_next;
	logic [31:0] prdata_reg, rd_val;
	logic pready_reg, pslverr_reg;

	// ************************************************
	// bus decode
	// ************************************************
	logic apb_setup, apb_wr, hit_w, hit_ins, hit_st, hit_mem, mapped;
	logic hit_aal, hit_aah, hit_abl, hit_abh, exec;
	logic [3:0] widx;
	logic [MA-1:0] midx;
	assign apb_setup = psel & ~penable;
	assign apb_wr  = psel & penable & pwrite & pready_reg;
	assign widx    = paddr[5:2];
	assign midx    = paddr[2 +: MA];
	assign hit_w   = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
	assign hit_ins = paddr == exec_pkg::A_INSTR;
	assign hit_st  = paddr == exec_pkg::A_STATUS;
	assign hit_aal = paddr == exec_pkg::A_ACCA_L;
	assign hit_aah = paddr == exec_pkg::A_ACCA_H;
	assign hit_abl = paddr == exec_pkg::A_ACCB_L;
	assign hit_abh = paddr == exec_pkg::A_ACCB_H;
	assign hit_mem = (paddr[11:10] == exec_pkg::MEM_WIN) &&
		(paddr[1:0] == 2'h0) && (32'(paddr[9:2]) < DEPTH);
	assign mapped = hit_w | hit_ins | hit_st | hit_aal | hit_aah |
		hit_abl | hit_abh | hit_mem;
	assign exec = apb_wr & hit_ins; // one write, one instruction

	// ************************************************
	// instruction fields
	// ************************************************
	logic [exec_pkg::INSTR_W-1:0] ins;
	logic [7:0] opc;
	logic [3:0] grp, s_reg, b_reg, d_reg;
	logic [1:0] form;
	logic [2:0] s_mode;
	assign ins    = pwdata[exec_pkg::INSTR_W-1:0];
	assign opc    = ins[exec_pkg::OPC_LSB +: exec_pkg::OPC_W];
	assign grp    = opc[7:4];
	assign form   = opc[1:0];
	assign s_reg  = ins[exec_pkg::SRC_LSB +: exec_pkg::RIX_W];
	assign b_reg  = ins[exec_pkg::BASE_LSB +: exec_pkg::RIX_W];
	assign d_reg  = ins[exec_pkg::DST_LSB +: exec_pkg::RIX_W];
	assign s_mode = ins[exec_pkg::SMODE_LSB +: 3];

	// ************************************************
	// class decode and legality
	// ************************************************
	logic is_add, is_and, is_asr, is_acc, is_mac, is_div;
	logic alu_ok, uses_src, legal;
	assign is_add = grp == exec_pkg::GRP_ADD;
	assign is_and = grp == exec_pkg::GRP_AND;
	assign is_asr = grp == exec_pkg::GRP_ASR;
	assign is_acc = opc[7:1] == exec_pkg::OP_ACC[7:1];
	assign is_mac = opc[7:2] == exec_pkg::OP_MAC[7:2];
	assign is_div = opc == exec_pkg::OP_DIV;
	assign alu_ok = (is_add & ~opc[2]) | (is_and & opc[3:2] == 2'h0) |
		(is_asr & opc[3:2] == 2'h0 & form != exec_pkg::FORM_L5);
	assign uses_src = (alu_ok & ~is_asr & form == exec_pkg::FORM_RRR) |
		(alu_ok & is_asr & form == exec_pkg::FORM_L10) | is_acc;
	assign legal = alu_ok | is_acc | is_mac | is_div;

	// ************************************************
	// source operand with address modes
	// ************************************************
	logic [DW-1:0] s_pre, s_post, s_idx, s_ea, s_upd, s_val;
	logic s_ind, s_ptr_we;
	assign s_pre  = (s_mode == exec_pkg::AM_PREINC) ? exec_pkg::STEP_P :
		(s_mode == exec_pkg::AM_PREDEC) ? exec_pkg::STEP_N : '0;
	assign s_post = (s_mode == exec_pkg::AM_POSTINC) ? exec_pkg::STEP_P :
		(s_mode == exec_pkg::AM_POSTDEC) ? exec_pkg::STEP_N : '0;
	assign s_idx  = (s_mode == exec_pkg::AM_INDEX) ? w_reg[b_reg] : '0;
	assign s_ind  = (s_mode != exec_pkg::AM_DIRECT) &&
		(s_mode <= exec_pkg::AM_INDEX);
	assign s_val  = s_ind ? mem[s_ea[MA:1]] : w_reg[s_reg];
	assign s_ptr_we = uses_src && (s_mode >= exec_pkg::AM_POSTINC) &&
		(s_mode <= exec_pkg::AM_PREDEC);

	// source pointer arithmetic
	ea_calc u_src (
		.ptr  (w_reg[s_reg]),
		.pre  (s_pre),
		.post (s_post),
		.idx  (s_idx),
		.ea   (s_ea),
		.upd  (s_upd)
	);

	// ************************************************
	// alu operands, destination and flag masks
	// ************************************************
	logic [MA-1:0] f_idx;
	logic [DW-1:0] f_val, alu_a, alu_b;
	logic [3:0] dsel;
	logic f_to_w0, alu_w_we, alu_m_we, upd_c, upd_dc, upd_ov, asr1;
	alu_if alu_bus ();
	assign f_idx   = ins[exec_pkg::FILE_LSB + 1 +: MA];
	assign f_val   = mem[f_idx];
	assign f_to_w0 = ins[exec_pkg::FILE_DEFAULT_FILE_OPERAND_REG];
	assign alu_a = (form == exec_pkg::FORM_FILE) ? f_val :
		(is_asr && form == exec_pkg::FORM_L10) ? s_val :
		(form == exec_pkg::FORM_L10) ? w_reg[d_reg] : w_reg[b_reg];
	assign alu_b = (form == exec_pkg::FORM_FILE) ? w_reg[exec_pkg::W0] :
		(form == exec_pkg::FORM_L10) ?
		DW'(ins[exec_pkg::L10_LSB +: exec_pkg::L10_W]) :
		(form == exec_pkg::FORM_L5) ?
		DW'(ins[exec_pkg::L5_LSB +: exec_pkg::L5_W]) :
		is_asr ? w_reg[s_reg] : s_val;
	assign alu_bus.a   = alu_a;
	assign alu_bus.b   = alu_b;
	assign alu_bus.cin = is_add & opc[exec_pkg::CARRY_BIT] &
		st_reg[exec_pkg::ST_C];
	assign alu_bus.op  = is_and ? exec_pkg::ALU_AND :
		~is_asr ? exec_pkg::ALU_ADD :
		(form == exec_pkg::FORM_RRR) ? exec_pkg::ALU_ASRN :
		exec_pkg::ALU_ASR1;
	assign asr1     = is_asr & form != exec_pkg::FORM_RRR;
	assign upd_c    = is_add | asr1;
	assign upd_dc   = is_add;
	assign upd_ov   = is_add | asr1;
	assign dsel     = (form == exec_pkg::FORM_FILE) ? exec_pkg::W0 : d_reg;
	assign alu_w_we = alu_ok & (form != exec_pkg::FORM_FILE | f_to_w0);
	assign alu_m_we = alu_ok & form == exec_pkg::FORM_FILE & ~f_to_w0;

	// shared adder, logic and shifter
	alu_core u_alu (
		.bus (alu_bus.alu)
	);

	// ************************************************
	// signed accumulator add
	// ************************************************
	logic acc_sel, acc_sat, acc_ovf;
	logic [3:0] slit;
	logic [AW-1:0] acc_cur, acc_op, acc_sh, acc_res;
	logic [AW:0] acc_sum;
	assign acc_sel = opc[0];
	assign slit    = ins[exec_pkg::SLIT_LSB +: exec_pkg::SHC_W];
	assign acc_cur = acc_sel ? accb_reg : acca_reg;
	assign acc_op  = {{(AW-32){s_val[DW-1]}}, s_val, {DW{1'b0}}};
	assign acc_sh  = slit[3] ? acc_op << (~slit + 4'h1) :
		$unsigned($signed(acc_op) >>> slit); // keep the sign
	assign acc_sum = {acc_cur[AW-1], acc_cur} + {acc_sh[AW-1], acc_sh};
	assign acc_sat = acc_sum[AW] != acc_sum[AW-1];
	assign acc_res = ~acc_sat ? acc_sum[AW-1:0] :
		acc_sum[AW] ? exec_pkg::ACC_MIN : exec_pkg::ACC_MAX;
	assign acc_ovf = ~(&acc_res[AW-1:31] | ~|acc_res[AW-1:31]);

	// ************************************************
	// multiply pairs and prefetch
	// ************************************************
	logic sqr, pair_ok, mac_ok, x_on, x_ix, y_on, y_ix;
	logic [2:0] pc;
	logic [3:0] m_reg, n_reg, xc, yc, x_reg, y_reg, xd, yd;
	logic signed [31:0] prod;
	logic [DW-1:0] x_post, x_idx, x_ea, x_upd, y_post, y_idx, y_ea, y_upd;
	assign sqr   = opc[1];
	assign pc    = ins[exec_pkg::PAIR_LSB +: 3];
	assign m_reg = sqr ? exec_pkg::W4 | {2'h0, pc[1:0]} :
		(pc < 3'h3) ? exec_pkg::W4 : (pc < 3'h5) ? exec_pkg::W5 : exec_pkg::W6;
	assign n_reg = sqr ? m_reg : (pc == 3'h0) ? exec_pkg::W5 :
		(pc == 3'h1 || pc == 3'h3) ? exec_pkg::W6 : exec_pkg::W7;
	assign pair_ok = sqr | (pc <= exec_pkg::PAIR_LAST);
	assign mac_ok  = is_mac & pair_ok;
	assign prod  = $signed(w_reg[m_reg]) * $signed(w_reg[n_reg]);
	assign xc    = ins[exec_pkg::XPF_LSB +: 4];
	assign x_on  = xc != exec_pkg::PF_NONE;
	assign x_ix  = xc == exec_pkg::PF_INDEX;
	assign x_reg = (xc[3] | x_ix) ? exec_pkg::W9 : exec_pkg::W8;
	assign x_post = x_ix ? '0 : exec_pkg::pf_delta(xc[2:0]);
	assign x_idx = x_ix ? w_reg[exec_pkg::W12] : '0;
	assign yc    = ins[exec_pkg::YPF_LSB +: 4];
	assign y_on  = yc != exec_pkg::PF_NONE;
	assign y_ix  = yc == exec_pkg::PF_INDEX;
	assign y_reg = (yc[3] | y_ix) ? exec_pkg::W11 : exec_pkg::W10;
	assign y_post = y_ix ? '0 : exec_pkg::pf_delta(yc[2:0]);
	assign y_idx = y_ix ? w_reg[exec_pkg::W12] : '0;
	assign xd = exec_pkg::W4 | {2'h0, ins[exec_pkg::XD_LSB +: 2]};
	assign yd = exec_pkg::W4 | {2'h0, ins[exec_pkg::YD_LSB +: 2]};

	// x space pointer
	ea_calc u_xpf (
		.ptr  (w_reg[x_reg]),
		.pre  ('0),
		.post (x_post),
		.idx  (x_idx),
		.ea   (x_ea),
		.upd  (x_upd)
	);

	// y space pointer
	ea_calc u_ypf (
		.ptr  (w_reg[y_reg]),
		.pre  ('0),
		.post (y_post),
		.idx  (y_idx),
		.ea   (y_ea),
		.upd  (y_upd)
	);

	// ************************************************
	// divide on a direct register pair
	// ************************************************
	logic [3:0] dv_m, dv_n;
	logic div_ok, bad_set;
	assign dv_m   = ins[exec_pkg::DIVM_LSB +: exec_pkg::RIX_W];
	assign dv_n   = ins[exec_pkg::DIVN_LSB +: exec_pkg::RIX_W];
	assign div_ok = is_div && (w_reg[dv_n] != '0);
	assign bad_set = exec & (~legal | (is_mac & ~pair_ok) |
		(is_div & ~div_ok));

	// working register next values, later writes win
	always_comb begin
		w_next = w_reg;
		if (apb_wr & hit_w)
			w_next[widx] = pwdata[DW-1:0];
		if (exec) begin
			if (s_ptr_we)
				w_next[s_reg] = s_upd;
			if (mac_ok & x_on & ~x_ix)
				w_next[x_reg] = x_upd;
			if (mac_ok & y_on & ~y_ix)
				w_next[y_reg] = y_upd;
			if (mac_ok & x_on)
				w_next[xd] = mem[x_ea[MA:1]];
			if (mac_ok & y_on)
				w_next[yd] = mem[y_ea[MA:1]];
			if (alu_w_we)
				w_next[dsel] = alu_bus.res;
			if (div_ok) begin
				w_next[exec_pkg::W0] = w_reg[dv_m] / w_reg[dv_n];
				w_next[exec_pkg::W1] = w_reg[dv_m] % w_reg[dv_n];
			end
		end
	end

	// status next value
	always_comb begin
		st_next = st_reg;
		if (apb_wr & hit_st)
			st_next = pwdata[exec_pkg::STATUS_W-1:0];
		if (exec & alu_ok) begin
			st_next[exec_pkg::ST_N] = alu_bus.res[DW-1];
			st_next[exec_pkg::ST_Z] = alu_bus.res == '0;
			if (upd_c)
				st_next[exec_pkg::ST_C] = alu_bus.c;
			if (upd_dc)
				st_next[exec_pkg::ST_DC] = alu_bus.dc;
			if (upd_ov)
				st_next[exec_pkg::ST_OV] = alu_bus.ov;
		end
		if (exec & is_acc & ~acc_sel) begin
			st_next[exec_pkg::ST_OA] = acc_ovf;
			st_next[exec_pkg::ST_SA] = st_reg[exec_pkg::ST_SA] | acc_sat;
		end
		if (exec & is_acc & acc_sel) begin
			st_next[exec_pkg::ST_OB] = acc_ovf;
			st_next[exec_pkg::ST_SB] = st_reg[exec_pkg::ST_SB] | acc_sat;
		end
		if (bad_set)
			st_next[exec_pkg::ST_BAD] = 1'b1;
	end

	// accumulator next values
	always_comb begin
		acca_next = acca_reg;
		accb_next = accb_reg;
		if (apb_wr & hit_aal)
			acca_next[31:0] = pwdata;
		if (apb_wr & hit_aah)
			acca_next[AW-1:32] = pwdata[AW-33:0];
		if (apb_wr & hit_abl)
			accb_next[31:0] = pwdata;
		if (apb_wr & hit_abh)
			accb_next[AW-1:32] = pwdata[AW-33:0];
		if (exec & is_acc & ~acc_sel)
			acca_next = acc_res;
		if (exec & is_acc & acc_sel)
			accb_next = acc_res;
		if (exec & mac_ok & ~opc[0])
			acca_next = AW'(prod);
		if (exec & mac_ok & opc[0])
			accb_next = AW'(prod);
	end

	// read data selection
	always_comb begin
		rd_val = '0;
		if (hit_w)
			rd_val[DW-1:0] = w_reg[widx];
		if (hit_ins)
			rd_val[exec_pkg::INSTR_W-1:0] = instr_reg;
		if (hit_st)
			rd_val[exec_pkg::STATUS_W-1:0] = st_reg;
		if (hit_aal)
			rd_val = acca_reg[31:0];
		if (hit_aah)
			rd_val[AW-33:0] = acca_reg[AW-1:32];
		if (hit_abl)
			rd_val = accb_reg[31:0];
		if (hit_abh)
			rd_val[AW-33:0] = accb_reg[AW-1:32];
		if (hit_mem)
			rd_val[DW-1:0] = mem[midx];
	end

	// data memory write port
	always_ff @(posedge pclk) begin
		if (exec & alu_m_we)
			mem[f_idx] <= alu_bus.res;
		else if (apb_wr & hit_mem)
			mem[midx] <= pwdata[DW-1:0];
	end

	// architectural state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_reg     <= '{default: '0};
			st_reg    <= exec_pkg::STATUS_RST;
			acca_reg  <= '0;
			accb_reg  <= '0;
			instr_reg <= '0;
		end else begin
			w_reg    <= w_next;
			st_reg   <= st_next;
			acca_reg <= acca_next;
			accb_reg <= accb_next;
			if (exec)
				instr_reg <= ins;
		end
	end

	// bus answer, one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= apb_setup;
			pslverr_reg <= apb_setup & ~mapped;
			if (apb_setup)
				prdata_reg <= rd_val;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
endmodule : operand_select_add_logic_shift

/* sim/operand_select_add_logic_shift_props.sv */
`timescale 1ns/1ps
module operand_select_add_logic_shift_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	// ************************************************
	// bus timing and decode properties
	// ************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup phase of a transfer
	wire setup_c = psel && !penable;
	a_ready_after_setup: assert property (setup_c |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_has_cause: assert property ($rose(pready) |-> $past(setup_c))
		else $error("ready without setup");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_unmapped: assert property (setup_c && paddr == 12'h0FC
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped access accepted");
	a_err_unaligned: assert property (setup_c && paddr[1:0] != 2'h0
		|=> pslverr)
		else $error("unaligned access accepted");
	a_mapped_ok: assert property (setup_c && paddr[11:2] < 10'h016
		&& paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped access refused");
	a_rdata_hold: assert property (!setup_c |=> $stable(prdata))
		else $error("read data moved");
	a_instr_width: assert property (setup_c && !pwrite && paddr == 12'h040
		|=> prdata[31:24] == 8'h00)
		else $error("instruction readback too wide");
endmodule : operand_select_add_logic_shift_props
bind operand_select_add_logic_shift operand_select_add_logic_shift_props
	u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));

/* sim/operand_select_add_logic_shift_tb.sv */
`timescale 1ns/1ps
module operand_select_add_logic_shift_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rv;
	logic        ev;
	int          bad_count;
	int          samples_checked;

	operand_select_add_logic_shift #(.DEPTH(16)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ************************************************
	// clock, bus tasks and checks
	// ************************************************
	always #50 pclk = ~pclk;

	task automatic complete_run;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one apb transfer, held until ready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			complete_run();
		end
	endtask : xfer

	task automatic rd(input logic [11:0] a, input string nm,
		input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(nm, rv, exp);
	endtask : rd

	task automatic ex(input logic [23:0] i);
		xfer(1'b1, 12'h040, {8'h00, i});
	endtask : ex

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_file;
		xfer(1'b1, 12'h000, 32'h7FFF);
		xfer(1'b1, 12'h404, 32'h0);
		xfer(1'b1, 12'h044, 32'h1);
		ex(24'h184002);
		rd(12'h000, "w0", 32'h8000);
		rd(12'h044, "status", 32'h01C);
		rd(12'h404, "mem", 32'h0);
	endtask : t_file

	task automatic t_rrr;
		xfer(1'b1, 12'h044, 32'h1);
		xfer(1'b1, 12'h008, 32'hFFFF);
		xfer(1'b1, 12'h00C, 32'h1);
		ex(24'h1A2304);
		rd(12'h010, "w4", 32'h1);
		rd(12'h044, "status", 32'h011);
		ex(24'h122305);
		rd(12'h014, "w5", 32'h0);
		rd(12'h044, "status", 32'h013);
	endtask : t_rrr

	task automatic t_lit;
		xfer(1'b1, 12'h044, 32'h0);
		xfer(1'b1, 12'h008, 32'h1);
		ex(24'h1321F9);
		rd(12'h024, "w9", 32'h20);
		rd(12'h044, "status", 32'h010);
		xfer(1'b1, 12'h018, 32'h5);
		ex(24'h113FF6);
		rd(12'h018, "w6", 32'h404);
	endtask : t_lit

	task automatic t_and;
		xfer(1'b1, 12'h044, 32'h015);
		xfer(1'b1, 12'h008, 32'h8F0F);
		xfer(1'b1, 12'h00C, 32'hF0FF);
		ex(24'h222306);
		rd(12'h018, "w6", 32'h800F);
		rd(12'h044, "status", 32'h01D);
		ex(24'h210006);
		rd(12'h044, "status", 32'h017);
	endtask : t_and

	task automatic t_asr;
		xfer(1'b1, 12'h044, 32'h004);
		xfer(1'b1, 12'h008, 32'h8003);
		xfer(1'b1, 12'h00C, 32'h4);
		ex(24'h310207);
		rd(12'h01C, "w7", 32'hC001);
		rd(12'h044, "status", 32'h009);
		ex(24'h323208);
		rd(12'h020, "w8", 32'h0);
		rd(12'h044, "status", 32'h003);
	endtask : t_asr

	task automatic t_dsp;
		xfer(1'b1, 12'h044, 32'h0);
		xfer(1'b1, 12'h010, 32'h3);
		xfer(1'b1, 12'h01C, 32'h2);
		ex(24'h505FE0);
		rd(12'h048, "acc lo", 32'h6);
		ex(24'h527FE0);
		rd(12'h048, "acc sq", 32'h4);
		ex(24'h50DFE0);
		rd(12'h044, "status", 32'h200);
		xfer(1'b1, 12'h00C, 32'h64);
		xfer(1'b1, 12'h014, 32'h7);
		ex(24'h580035);
		rd(12'h000, "quot", 32'hE);
		rd(12'h004, "rem", 32'h2);
	endtask : t_dsp

	task automatic t_bus;
		rd(12'h0FC, "unmapped", 32'h0);
		chk("err", {31'h0, ev}, 32'h1);
		rd(12'h042, "unaligned", 32'h0);
		chk("err", {31'h0, ev}, 32'h1);
		rd(12'h040, "instr", 32'h580035);
	endtask : t_bus

	// accumulator add: negative source shifted right, then saturation
	task automatic t_acc;
		xfer(1'b1, 12'h044, 32'h0);
		xfer(1'b1, 12'h048, 32'h0);
		xfer(1'b1, 12'h04C, 32'h0);
		xfer(1'b1, 12'h008, 32'h2);
		xfer(1'b1, 12'h404, 32'h8000);
		ex(24'h400241);
		rd(12'h04C, "acc hi", 32'hFF);
		rd(12'h008, "w2", 32'h4);
		xfer(1'b1, 12'h048, 32'hFFFFFFFF);
		xfer(1'b1, 12'h04C, 32'h7F);
		ex(24'h400300);
		rd(12'h048, "acc sat", 32'hFFFFFFFF);
		rd(12'h044, "status", 32'h0A0);
	endtask : t_acc

	// x prefetch with post step, y prefetch indexed by w12
	task automatic t_pf;
		xfer(1'b1, 12'h020, 32'h2);
		xfer(1'b1, 12'h030, 32'h4);
		xfer(1'b1, 12'h408, 32'h1234);
		ex(24'h5004F6);
		rd(12'h020, "w8", 32'h4);
		rd(12'h018, "w6", 32'h8000);
		rd(12'h01C, "w7", 32'h1234);
		rd(12'h02C, "w11", 32'h0);
	endtask : t_pf

	// reset, then the scenarios in turn
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h044, "status", 32'h0);
		t_file();
		t_rrr();
		t_lit();
		t_and();
		t_asr();
		t_dsp();
		t_bus();
		t_acc();
		t_pf();
		complete_run();
	end
endmodule : operand_select_add_logic_shift_tb
